//--- design/wit_cfg.svh
/*
 watchdog interval timer constants: register addresses, passwords, field positions, reset values, timing.
 assumes inclusion by bare name from the design files.
*/
`ifndef WIT_CFG_SVH
`define WIT_CFG_SVH

`define WIT_ADDR_TCS_WR      16'hfeec
`define WIT_ADDR_TCS_RD      16'hfeec
`define WIT_ADDR_CNT_RD      16'hfeed
`define WIT_ADDR_RCS_WR      16'hff14
`define WIT_ADDR_RCS_RD      16'hff15
`define WIT_ADDR_IRQ_STAT    16'hff16
`define WIT_ADDR_IRQ_MASK    16'hff17

`define WIT_PW_CNT           8'h5a
`define WIT_PW_TCS           8'ha5
`define WIT_PW_RCS_CLR       8'ha5
`define WIT_PW_RCS_OE        8'h5a

`define WIT_BIT_OVF          7
`define WIT_BIT_MODE         6
`define WIT_BIT_RUN          5
`define WIT_BIT_WRF          7
`define WIT_BIT_ROE          6

`define WIT_TCS_FIXED        8'h18
`define WIT_RCS_FIXED        8'h3f
`define WIT_RCS_CLR_DATA     8'h00
`define WIT_CNT_RESET        8'h00
`define WIT_CNT_MAX          8'hff

`define WIT_CLK_NS           20
`define WIT_RST_PULSE_CLKS   132
`define WIT_RST_PULSE_NS     (`WIT_RST_PULSE_CLKS * `WIT_CLK_NS)

`endif

//--- design/wit_pkg.sv
/*
 watchdog interval timer types.
 assumes nothing of its surroundings.
*/
package wit_pkg;
    typedef enum logic [1:0] {
        WIT_PULSE_IDLE,
        WIT_PULSE_DRIVE
    } wit_pulse_state_t;
endpackage

//--- design/wit_prescaler.sv
/*
 prescaler: free-running divider giving a one-cycle enable at the selected rate.
 assumes one clock, clear when the timer is stopped.
*/
`timescale 1ns/1ps
module wit_prescaler #(
    parameter int DIV_W = 12
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       clear,
    input  wire logic [2:0] select,
    // enable out
    output logic            tick
);
    logic [DIV_W-1:0] div_count;

    function automatic logic [DIV_W-1:0] wit_div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    wit_div_mask = DIV_W'(12'h001);
            3'h1:    wit_div_mask = DIV_W'(12'h01f);
            3'h2:    wit_div_mask = DIV_W'(12'h03f);
            3'h3:    wit_div_mask = DIV_W'(12'h07f);
            3'h4:    wit_div_mask = DIV_W'(12'h0ff);
            3'h5:    wit_div_mask = DIV_W'(12'h1ff);
            3'h6:    wit_div_mask = DIV_W'(12'h7ff);
            default: wit_div_mask = DIV_W'(12'hfff);
        endcase
    endfunction

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_count <= '0;
        else if (clear)
            div_count <= '0;
        else
            div_count <= div_count + DIV_W'(1);
    end

    // pulse once per 2,32,...,4096 clocks
    always_comb
    begin
        tick = !clear && ((div_count & wit_div_mask(select)) == wit_div_mask(select)); // R10
    end
endmodule

//--- design/wit_reset_pulse.sv
/*
 reset pulse stretcher: drives the external reset pin low for a fixed count.
 assumes a one-cycle start request on the same clock.
*/
`timescale 1ns/1ps
`include "wit_cfg.svh"
module wit_reset_pulse #(
    parameter int PULSE_CLKS = `WIT_RST_PULSE_CLKS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // request
    input  wire logic start,
    // pin drive
    output logic      drive
);
    logic [7:0]              remain;
    wit_pkg::wit_pulse_state_t state;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state  <= wit_pkg::WIT_PULSE_IDLE;
            remain <= 8'h00;
        end
        else
        begin
            case (state)
                wit_pkg::WIT_PULSE_IDLE:
                    if (start)
                    begin
                        state  <= wit_pkg::WIT_PULSE_DRIVE;
                        remain <= 8'(PULSE_CLKS - 1);
                    end
                wit_pkg::WIT_PULSE_DRIVE:
                    if (remain == 8'h00)
                        state <= wit_pkg::WIT_PULSE_IDLE;
                    else
                        remain <= remain - 8'h01; // R15
                default:
                    state <= wit_pkg::WIT_PULSE_IDLE;
            endcase
        end
    end

    always_comb
    begin
        drive = (state == wit_pkg::WIT_PULSE_DRIVE);
    end
endmodule

//--- design/wit_watchdog.sv
/*
 watchdog / interval timer: 8-bit counter, control/status, reset control, interrupt status and mask.
 assumes a one-cycle strobe register port with 16-bit write words, byte writes flagged by
 wr_word low, chip reset applied externally on rst_n, the chip's own reset fed by wdt_reset_req.
*/
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "wit_cfg.svh"
// Functional notes
// R1: an 8-bit up-counter advances on each selected prescaled pulse while the run enable is 1.
// R2: a wrap from ff to 00 is an overflow and sets the overflow flag in interval mode.
// R3: the counter is forced to zero and held while reset or while the run enable is 0.
// R4: control bits 7..5 clear on reset and standby, clock select clears on reset only.
// R5: the overflow flag clears only by writing 0 after reading it as 1, and is never set by software.
// R6: no overflow flag is set in watchdog mode.
// R7: mode select 0 gives interval mode (reset value), 1 gives watchdog mode.
// R8: an enabled overflow gives a chip reset in watchdog mode and an interrupt in interval mode.
// R9: control bits 4 and 3 cannot be written and read as 1.
// R10: clock select picks clk/2,32,64,128,256,512,2048,4096.
// R11: the watchdog reset reaches the external pin only when reset output is enabled.
// R12: counter and control share a write address, control reads there and the counter one above.
// R13: counter and control writes are word writes with password 5a (counter) or a5 (control).
// R14: reset control takes word writes only, a5 with 00 clears the reset flag, 5a loads bit 6.
// R15: a watchdog overflow sets the reset flag and, if enabled, drives the pin low 132 clocks.
// R16: reset output enable survives a watchdog reset but clears with the flag on a pin reset.
// R17: an overflow comes 256 prescaled pulses after the counter starts at zero.
module wit_watchdog (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        standby,
    // register port
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_word,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [7:0]       rdata,
    // external reset pin, open drain
    input  wire logic        ext_reset_pin_in,
    output logic             ext_reset_pin_out,
    output logic             ext_reset_pin_oe,
    // chip reset and interrupt
    output logic             wdt_reset_req,
    output logic             irq
);
    logic [7:0] wdt_counter;
    logic       overflow_flag;
    logic       timer_mode_select;
    logic       timer_run_enable;
    logic [2:0] clock_select;
    logic       watchdog_reset_flag;
    logic       reset_output_enable;
    logic       ovf_seen;
    logic       irq_status;
    logic       irq_mask;
    logic       pin_sync1;
    logic       pin_sync2;
    logic       tick;
    logic       overflow;
    logic       pulse_drive;
    logic       wr_cnt;
    logic       wr_tcs;
    logic       wr_rcs;
    logic [7:0] tcs_value;
    logic [7:0] next_rdata;
    logic       wr_rcs_clr;
    logic       wr_rcs_oe;
    logic       oe_echo1;
    logic       oe_echo2;
    logic       self_driving;

    function automatic logic wit_hit(input logic [15:0] a, input logic [15:0] ref_addr);
        wit_hit = (a == ref_addr);
    endfunction

    // own pin drive echoes through the synchroniser for two cycles after the enable drops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_echo1 <= 1'b0;
            oe_echo2 <= 1'b0;
        end
        else
        begin
            oe_echo1 <= ext_reset_pin_oe;
            oe_echo2 <= oe_echo1;
        end
    end

    // pin synchroniser; low on the pin is an external reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync1 <= 1'b1;
            pin_sync2 <= 1'b1;
        end
        else
        begin
            pin_sync1 <= ext_reset_pin_in;
            pin_sync2 <= pin_sync1;
        end
    end

    always_comb
    begin
        wr_cnt   = wr && wr_word && wit_hit(addr, `WIT_ADDR_TCS_WR) && wdata[15:8] == `WIT_PW_CNT; // R12 R13
        wr_tcs   = wr && wr_word && wit_hit(addr, `WIT_ADDR_TCS_WR) && wdata[15:8] == `WIT_PW_TCS; // R12 R13
        wr_rcs   = wr && wr_word && wit_hit(addr, `WIT_ADDR_RCS_WR); // R14
        wr_rcs_clr = wr_rcs && wdata[15:8] == `WIT_PW_RCS_CLR && wdata[7:0] == `WIT_RCS_CLR_DATA; // R14
        wr_rcs_oe  = wr_rcs && wdata[15:8] == `WIT_PW_RCS_OE; // R14
        self_driving = pulse_drive || ext_reset_pin_oe || oe_echo1 || oe_echo2; // R16
        overflow = timer_run_enable && tick && wdt_counter == `WIT_CNT_MAX; // R2 R17
        tcs_value = `WIT_TCS_FIXED; // R9
        tcs_value[`WIT_BIT_OVF]  = overflow_flag;
        tcs_value[`WIT_BIT_MODE] = timer_mode_select;
        tcs_value[`WIT_BIT_RUN]  = timer_run_enable;
        tcs_value[2:0]           = clock_select;
    end

    wit_prescaler #(
        .DIV_W (12)
    ) u_prescaler (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (!timer_run_enable),
        .select (clock_select),
        .tick   (tick)
    );

    wit_reset_pulse #(
        .PULSE_CLKS (`WIT_RST_PULSE_CLKS)
    ) u_reset_pulse (
        .clk   (clk),
        .rst_n (rst_n),
        .start (overflow && timer_mode_select && reset_output_enable), // R11 R15
        .drive (pulse_drive)
    );

    // counter; a stopped timer or standby holds zero over a counter write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wdt_counter <= `WIT_CNT_RESET;
        else if (!timer_run_enable || standby)
            wdt_counter <= `WIT_CNT_RESET; // R3
        else if (wr_cnt)
            wdt_counter <= wdata[7:0];
        else if (tick)
            wdt_counter <= wdt_counter + 8'h01; // R1
    end

    // control/status mode and run bits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_mode_select <= 1'b0; // R7
            timer_run_enable  <= 1'b0;
        end
        else if (standby)
        begin
            timer_mode_select <= 1'b0; // R4
            timer_run_enable  <= 1'b0;
        end
        else if (wr_tcs)
        begin
            timer_mode_select <= wdata[`WIT_BIT_MODE];
            timer_run_enable  <= wdata[`WIT_BIT_RUN];
        end
    end

    // clock select keeps its value in standby
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            clock_select <= 3'h0; // R4
        else if (wr_tcs)
            clock_select <= wdata[2:0];
    end

    // overflow flag with read-then-write-0 clear; a set wins over a clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_flag <= 1'b0;
            ovf_seen      <= 1'b0;
        end
        else if (standby)
        begin
            overflow_flag <= 1'b0; // R4
            ovf_seen      <= 1'b0;
        end
        else if (overflow && !timer_mode_select)
        begin
            overflow_flag <= 1'b1; // R2 R6
            ovf_seen      <= ovf_seen;
        end
        else
        begin
            if (rd && wit_hit(addr, `WIT_ADDR_TCS_RD) && overflow_flag)
                ovf_seen <= 1'b1;
            if (wr_tcs && !wdata[`WIT_BIT_OVF] && ovf_seen)
            begin
                overflow_flag <= 1'b0; // R5
                ovf_seen      <= 1'b0;
            end
        end
    end

    // reset control: flag and output enable
    // a trip wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_reset_flag <= 1'b0;
            reset_output_enable <= 1'b0;
        end
        else if (!pin_sync2 && !self_driving)
        begin
            watchdog_reset_flag <= 1'b0; // R16
            reset_output_enable <= 1'b0;
        end
        else
        begin
            if (overflow && timer_mode_select)
                watchdog_reset_flag <= 1'b1; // R15
            else if (wr_rcs_clr)
                watchdog_reset_flag <= 1'b0; // R14
            if (wr_rcs_oe)
                reset_output_enable <= wdata[`WIT_BIT_ROE]; // R14
        end
    end

    // chip reset request and pin drive
    // pin level is high in reset and low after it; the open-drain pin is pulled only through the enable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdt_reset_req     <= 1'b0;
            ext_reset_pin_out <= 1'b1;
            ext_reset_pin_oe  <= 1'b0;
        end
        else
        begin
            wdt_reset_req     <= overflow && timer_mode_select; // R8
            ext_reset_pin_out <= 1'b0;
            ext_reset_pin_oe  <= pulse_drive; // R11
        end
    end

    // interrupt status and mask
    // status is sticky until a one is written; irq follows one cycle later
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= 1'b0;
            irq_mask   <= 1'b0;
            irq        <= 1'b0;
        end
        else
        begin
            if (overflow && !timer_mode_select)
                irq_status <= 1'b1; // R8
            else if (wr && wit_hit(addr, `WIT_ADDR_IRQ_STAT) && wdata[0])
                irq_status <= 1'b0;
            if (wr && wit_hit(addr, `WIT_ADDR_IRQ_MASK))
                irq_mask <= wdata[0];
            irq <= irq_status && irq_mask;
        end
    end

    // read mux
    // unmapped addresses read as zero
    always_comb
    begin
        next_rdata = 8'h00;
        case (addr)
            `WIT_ADDR_TCS_RD:   next_rdata = tcs_value; // R12
            `WIT_ADDR_CNT_RD:   next_rdata = wdt_counter; // R12
            `WIT_ADDR_RCS_RD:   next_rdata = {watchdog_reset_flag, reset_output_enable, 6'(`WIT_RCS_FIXED)};
            `WIT_ADDR_IRQ_STAT: next_rdata = {7'h00, irq_status};
            `WIT_ADDR_IRQ_MASK: next_rdata = {7'h00, irq_mask};
            default:            next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end
endmodule

//--- testbench/tb_top.sv
/*
 self-checking bench for the watchdog interval timer.
 assumes the design files under design/ and a pull-up on the reset pin.
*/
`timescale 1ns/1ps
module tb_top;
    logic        clk;
    logic        rst_n;
    logic        standby;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr_word;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        ext_drv_n;
    logic        pin_out;
    logic        pin_oe;
    logic        wdt_reset_req;
    logic        irq;
    wire         pin = (pin_oe ? pin_out : 1'b1) & ext_drv_n;
    int          err_count;
    int          num_checks;
    int          div [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

    wit_watchdog wit_watchdog_inst (
        .clk               (clk),
        .rst_n             (rst_n),
        .standby           (standby),
        .addr              (addr),
        .wdata             (wdata),
        .wr_word           (wr_word),
        .wr                (wr),
        .rd                (rd),
        .rdata             (rdata),
        .ext_reset_pin_in  (pin),
        .ext_reset_pin_out (pin_out),
        .ext_reset_pin_oe  (pin_oe),
        .wdt_reset_req     (wdt_reset_req),
        .irq               (irq)
    );

    always #10 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr16(input logic [15:0] a, input logic [15:0] d, input logic w = 1'b1);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_word <= w;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd8(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic chkrd(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd8(a, v);
        chk(v, exp);
    endtask

    task automatic wait_req;
        int n;
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_reset;
        chkrd(16'hfeec, 8'h18);
        chkrd(16'hfeed, 8'h00);
        chkrd(16'hff15, 8'h3f);
        chkrd(16'h0100, 8'h00);
        wr16(16'hfeec, 16'ha520, 1'b0);
        chkrd(16'hfeec, 8'h18);
        wr16(16'hfeec, 16'h5520);
        chkrd(16'hfeec, 8'h18);
        $display("done: reset values");
    endtask

    task automatic t_clock_select;
        logic [7:0] v;
        for (int s = 0; s < 8; s++)
        begin
            wr16(16'hfeec, {8'ha5, 5'b00100, s[2:0]});
            repeat (2 * div[s]) @(posedge clk);
            rd8(16'hfeed, v);
            chk({7'h00, v inside {8'h02, 8'h03}}, 8'h01);
            wr16(16'hfeec, {8'ha5, 5'b00000, s[2:0]});
            chkrd(16'hfeed, 8'h00);
        end
        $display("done: clock select");
    endtask

    task automatic t_interval;
        int n;
        wr16(16'hff17, 16'h0001);
        wr16(16'hfeec, 16'ha520);
        n = 0;
        while (irq !== 1'b1 && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, n >= 508 && n <= 518}, 8'h01);
        chkrd(16'hfeec, 8'hb8);
        wr16(16'hfeec, 16'ha520);
        chkrd(16'hfeec, 8'h38);
        wr16(16'hfeec, 16'ha5a0);
        chkrd(16'hfeec, 8'h38);
        wr16(16'hff16, 16'h0001);
        chkrd(16'hff16, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr16(16'hff17, 16'h0000);
        repeat (600) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        chkrd(16'hff16, 8'h01);
        chkrd(16'hfeec, 8'hb8);
        wr16(16'hfeec, 16'ha500);
        chkrd(16'hfeec, 8'h18);
        wr16(16'hff16, 16'h0001);
        $display("done: interval mode");
    endtask

    task automatic t_watchdog;
        wr16(16'hfeec, 16'ha560);
        wr16(16'hfeec, 16'h5af0);
        wait_req();
        chkrd(16'hff15, 8'hbf);
        chk({7'h00, pin_oe}, 8'h00);
        chkrd(16'hfeec, 8'h78);
        wr16(16'hff14, 16'h5a40);
        wr16(16'hfeec, 16'h5af0);
        wait_req();
        chk({7'h00, wdt_reset_req}, 8'h01);
        chkrd(16'hff15, 8'hff);
        chk({7'h00, pin_oe}, 8'h01);
        wr16(16'hff14, 16'ha500);
        chkrd(16'hff15, 8'h7f);
        wr16(16'hfeec, 16'ha500);
        repeat (140) @(posedge clk);
        chkrd(16'hff15, 8'h7f);
        ext_drv_n <= 1'b0;
        repeat (4) @(posedge clk);
        ext_drv_n <= 1'b1;
        repeat (4) @(posedge clk);
        chkrd(16'hff15, 8'h3f);
        $display("done: watchdog mode");
    endtask

    task automatic t_standby;
        wr16(16'hfeec, 16'ha565);
        @(posedge clk);
        standby <= 1'b1;
        repeat (2) @(posedge clk);
        standby <= 1'b0;
        chkrd(16'hfeec, 8'h1d);
        chkrd(16'hfeed, 8'h00);
        $display("done: standby");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        standby = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        wr_word = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        ext_drv_n = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_clock_select();
        t_interval();
        t_watchdog();
        t_standby();
        wrap_up();
    end

    // hang guard, well beyond the expected run
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule

bind wit_watchdog wit_watchdog_chk wit_watchdog_chk_inst (
    .clk               (clk),
    .rst_n             (rst_n),
    .addr              (addr),
    .rd                (rd),
    .rdata             (rdata),
    .ext_reset_pin_out (ext_reset_pin_out),
    .ext_reset_pin_oe  (ext_reset_pin_oe),
    .wdt_reset_req     (wdt_reset_req)
);

//--- testbench/wit_watchdog_properties.sv
/*
 port checker for the watchdog interval timer.
 assumes a bind onto wit_watchdog, one clock, rst_n active low.
*/
`timescale 1ns/1ps
module wit_watchdog_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [15:0] addr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    // reset outputs
    input wire logic        ext_reset_pin_out,
    input wire logic        ext_reset_pin_oe,
    input wire logic        wdt_reset_req
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [8:0] oe_len;

    // length of the current pin drive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            oe_len <= 9'h000;
        else
            oe_len <= ext_reset_pin_oe ? oe_len + 9'h001 : 9'h000;
    end

    sequence s_rd(logic [15:0] a);
        rd && addr == a;
    endsequence
    sequence s_trip;
        wdt_reset_req ##1 s_rd(16'hff15);
    endsequence

    a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("rdata set without a read");
    a_ctl_fixed_ones: assert property (s_rd(16'hfeec) |=> rdata[4:3] == 2'b11)
        else $error("control bits 4:3 not ones");
    a_rcs_fixed_ones: assert property (s_rd(16'hff15) |=> rdata[5:0] == 6'h3f)
        else $error("reset control bits 5:0 not ones");
    a_req_one_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("chip reset request longer than one cycle");
    a_trip_flag_set: assert property (s_trip |=> rdata[7])
        else $error("reset flag not set after trip");
    a_pulse_exact: assert property ($fell(ext_reset_pin_oe) |-> oe_len == 9'h084)
        else $error("pin drive length wrong");
    a_pulse_bound: assert property (oe_len <= 9'h084)
        else $error("pin drive too long");
    a_oe_has_cause: assert property ($rose(ext_reset_pin_oe) |-> $past(wdt_reset_req) || $past(wdt_reset_req, 2))
        else $error("pin driven without a trip");
    a_pin_drives_low: assert property (ext_reset_pin_oe |-> !ext_reset_pin_out)
        else $error("pin driven high");
endmodule
